/* File: charger_irq_pkg.sv */
// shared constants and types for the charger interrupt mask block
package charger_irq_pkg;
  localparam logic [7:0] MASK_FAULTS_ADDR = 8'h1e;
  localparam logic [7:0] MASK_EVENTS_ADDR = 8'h1f;
  localparam logic [7:0] IRQ_AND_OTG_STATUS_ADDR = 8'h20;
  localparam logic [7:0] CAUSE_LOW_ADDR = 8'h3c;
  localparam logic [7:0] CAUSE_MID_ADDR = 8'h3d;
  localparam logic [7:0] CAUSE_HIGH_ADDR = 8'h3e;
  localparam logic [7:0] MASK_FAULTS_RESET = 8'h00;
  localparam logic [7:0] MASK_EVENTS_RESET = 8'h00;
  localparam logic MASK_BUS_ERROR_RESET = 1'b0;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam int MASK_BUS_ERROR_BIT = 7;
  localparam int NUM_EVENTS = 17;
  localparam int EVT_THERMAL = 0;
  localparam int EVT_REGULATOR = 1;
  localparam int EVT_CHG_BAT_OV = 2;
  localparam int EVT_SAFETY_TIMER = 3;
  localparam int EVT_OTG_BATTERY = 4;
  localparam int EVT_INPUT_WINDOW = 5;
  localparam int EVT_BAT_GOOD_DROP = 6;
  localparam int EVT_CHARGE_DONE = 7;
  localparam int EVT_OTG_TEMP = 8;
  localparam int EVT_SUSPEND = 9;
  localparam int EVT_HIGH_IMP = 10;
  localparam int EVT_DATA_READY = 11;
  localparam int EVT_LIGHT_LOAD = 12;
  localparam int EVT_HICCUP = 13;
  localparam int EVT_WATCHDOG = 14;
  localparam int EVT_SWITCH_OC = 15;
  localparam int EVT_BUS_ERROR = 16;
  localparam logic [2:0] OTG_HICCUP_CODE = 3'h3;
  localparam logic [2:0] OTG_LIGHT_LOAD_CODE = 3'h4;
  // value is arbitrary
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h09;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_WIDTH = 27;
  // bus clock and data idle high, so their sync stages start there
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 27'h6000000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } i2c_state_t;
endpackage : charger_irq_pkg

/* File: irq_chan_if.sv */
// one interrupt event channel between the register logic and its latch
`timescale 1ns/1ps
interface irq_chan_if;
  logic level;
  logic mask;
  logic clear;
  logic pending;
  modport chan (input level, input mask, input clear, output pending);
  modport ctrl (output level, output mask, output clear, input pending);
endinterface : irq_chan_if

/* File: irq_event_chan.sv */
// edge detector and pending latch for one interrupt event
`timescale 1ns/1ps
module irq_event_chan (
  input wire logic core_clk,
  input wire logic reset_n,
  irq_chan_if.chan chan
);
  logic levelPrev;
  logic pendingFlag;
  logic rise;

  assign rise = chan.level && !levelPrev;
  assign chan.pending = pendingFlag;

  // reset high so a level already true after reset is not an edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      levelPrev <= 1'b1;
    end else begin
      levelPrev <= chan.level;
    end
  end

  // masked edges are dropped: unmasking later raises no stale alert
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pendingFlag <= 1'b0;
    end else if (rise && !chan.mask) begin
      pendingFlag <= 1'b1;
    end else if (chan.clear) begin
      pendingFlag <= 1'b0;
    end
  end

  a_set_beats_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    rise && !chan.mask && chan.clear |=> pendingFlag)
    else $error("event lost against a clear");
  a_masked_edge_dropped: assert property (@(posedge core_clk) disable iff (!reset_n)
    chan.mask && !pendingFlag |=> !pendingFlag)
    else $error("masked event became pending");
endmodule : irq_event_chan

/* File: charger_irq_mask_logic.sv */
// interrupt mask logic with serial register port for the charger
// Notes on behaviour
// - charge terminated or full raises alert unless masked
// - battery-good falling edge raises alert unless masked
// - charge-mode input over/undervoltage raises alert unless masked
// - reverse-mode battery cutoff or overvoltage raises alert
// - either safety timer expiring in charge raises alert
// - charge-mode battery overvoltage raises alert unless masked
// - regulator overcurrent or undervoltage raises alert
// - thermal shutdown raises alert unless masked
// - power switch overcurrent raises alert unless masked
// - watchdog expiry raises alert unless masked
// - entering hiccup state raises alert unless masked
// - entering light-load-disable raises alert unless masked
// - converter data-ready rising edge raises alert
// - entering high-impedance state raises alert unless masked
// - entering charge suspend raises alert unless masked
// - reverse-mode battery hot or cold raises alert
// - serial bus or command fault raises alert
`timescale 1ns/1ps
module charger_irq_mask_logic #(
  parameter logic [6:0] DEV_ADDR = charger_irq_pkg::DEFAULT_DEV_ADDR
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  output logic hostAlertPin_n,
  input wire logic chargeMode,
  input wire logic reverseSupplyMode,
  input wire logic chargeTerminatedState,
  input wire logic chargeFullState,
  input wire logic batteryGood,
  input wire logic chargeInputFault,
  input wire logic lowBatteryTimerExpired,
  input wire logic fastChargeTimerExpired,
  input wire logic chargeBatteryOvervolt,
  input wire logic regulatorFault,
  input wire logic thermalShutdown,
  input wire logic switchOvercurrent,
  input wire logic watchdogExpired,
  input wire logic [2:0] otgState,
  input wire logic converterDataReady,
  input wire logic highImpedanceState,
  input wire logic chargeSuspend,
  input wire logic otgBatteryHot,
  input wire logic otgBatteryCold,
  input wire logic otgBatteryCutoff,
  input wire logic otgBatteryOvervolt,
  input wire logic otgBatteryCc,
  input wire logic otgOutputCc
);
  localparam int NEV = charger_irq_pkg::NUM_EVENTS;

  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_bad_addr
    $error("device address lies in a reserved serial bus range");
  end

  logic [charger_irq_pkg::SYNC_WIDTH-1:0] rawIn;
  logic [charger_irq_pkg::SYNC_WIDTH-1:0] syncA;
  logic [charger_irq_pkg::SYNC_WIDTH-1:0] syncB;
  logic sclS, sdaS, chgS, otgS, termS, fullS, goodS, inFaultS;
  logic lowTmrS, fastTmrS, chgOvS, regFaultS, thermS, switchOcS, wdogS;
  logic [2:0] otgStateS;
  logic dataRdyS, hizS, suspendS, hotS, coldS, cutoffS, batOvS, batCcS, outCcS;
  logic sclPrev;
  logic sdaPrev;
  logic startSeen, stopSeen, sclRise, sclFall;

  charger_irq_pkg::i2c_state_t state;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txShift;
  logic [7:0] ptr;
  logic rwBit;
  logic masterAck;
  logic inByte, byteDone, addrMatch, loadTx, wrStrobe, wrMapped;
  logic [7:0] readData;
  logic busErrorPulse;

  logic [7:0] maskFaults;
  logic [7:0] maskEvents;
  logic maskBusError;
  logic [NEV-1:0] eventLevel;
  logic [NEV-1:0] maskVec;
  logic [NEV-1:0] clearVec;
  logic [NEV-1:0] pendVec;

  // every pin and analog flag crosses into core_clk through two flops
  assign rawIn = {sclIn, sdaIn, chargeMode, reverseSupplyMode, chargeTerminatedState,
    chargeFullState, batteryGood, chargeInputFault, lowBatteryTimerExpired,
    fastChargeTimerExpired, chargeBatteryOvervolt, regulatorFault, thermalShutdown,
    switchOvercurrent, watchdogExpired, otgState, converterDataReady, highImpedanceState,
    chargeSuspend, otgBatteryHot, otgBatteryCold, otgBatteryCutoff, otgBatteryOvervolt,
    otgBatteryCc, otgOutputCc};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= charger_irq_pkg::SYNC_RESET;
      syncB <= charger_irq_pkg::SYNC_RESET;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  assign {sclS, sdaS, chgS, otgS, termS, fullS, goodS, inFaultS, lowTmrS, fastTmrS,
    chgOvS, regFaultS, thermS, switchOcS, wdogS, otgStateS, dataRdyS, hizS, suspendS,
    hotS, coldS, cutoffS, batOvS, batCcS, outCcS} = syncB;

  // idle bus is high; resetting these high avoids a false start
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopSeen = sclS && sclPrev && !sdaPrev && sdaS;
  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;

  assign inByte = state == charger_irq_pkg::ST_ADDR || state == charger_irq_pkg::ST_REG ||
    state == charger_irq_pkg::ST_WDATA;
  assign byteDone = bitCnt == charger_irq_pkg::BITS_PER_BYTE;
  assign addrMatch = shiftIn[7:1] == DEV_ADDR;
  assign wrStrobe = sclFall && state == charger_irq_pkg::ST_WDATA && byteDone;
  assign wrMapped = ptr == charger_irq_pkg::MASK_FAULTS_ADDR ||
    ptr == charger_irq_pkg::MASK_EVENTS_ADDR || ptr == charger_irq_pkg::IRQ_AND_OTG_STATUS_ADDR;
  assign loadTx = sclFall && ((state == charger_irq_pkg::ST_ADDR_ACK && rwBit) ||
    (state == charger_irq_pkg::ST_RDATA_ACK && masterAck));

  // byte-level serial slave state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= charger_irq_pkg::ST_IDLE;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      rwBit <= 1'b0;
      masterAck <= 1'b0;
    end else if (startSeen) begin
      state <= charger_irq_pkg::ST_ADDR;
      bitCnt <= 4'h0;
    end else if (stopSeen) begin
      state <= charger_irq_pkg::ST_IDLE;
      bitCnt <= 4'h0;
    end else if (sclRise) begin
      if (inByte) begin
        shiftIn <= {shiftIn[6:0], sdaS};
      end
      if (inByte || state == charger_irq_pkg::ST_RDATA) begin
        bitCnt <= bitCnt + 4'h1;
      end
      if (state == charger_irq_pkg::ST_RDATA_ACK) begin
        masterAck <= !sdaS;
      end
    end else if (sclFall) begin
      case (state)
        charger_irq_pkg::ST_ADDR: begin
          if (byteDone) begin
            state <= addrMatch ? charger_irq_pkg::ST_ADDR_ACK : charger_irq_pkg::ST_IDLE;
            rwBit <= shiftIn[0];
          end
        end
        charger_irq_pkg::ST_ADDR_ACK: begin
          state <= rwBit ? charger_irq_pkg::ST_RDATA : charger_irq_pkg::ST_REG;
          bitCnt <= 4'h0;
        end
        charger_irq_pkg::ST_REG: begin
          if (byteDone) begin
            state <= charger_irq_pkg::ST_REG_ACK;
          end
        end
        charger_irq_pkg::ST_REG_ACK, charger_irq_pkg::ST_WDATA_ACK: begin
          state <= charger_irq_pkg::ST_WDATA;
          bitCnt <= 4'h0;
        end
        charger_irq_pkg::ST_WDATA: begin
          if (byteDone) begin
            state <= charger_irq_pkg::ST_WDATA_ACK;
          end
        end
        charger_irq_pkg::ST_RDATA: begin
          if (byteDone) begin
            state <= charger_irq_pkg::ST_RDATA_ACK;
          end
        end
        charger_irq_pkg::ST_RDATA_ACK: begin
          state <= masterAck ? charger_irq_pkg::ST_RDATA : charger_irq_pkg::ST_IDLE;
          bitCnt <= 4'h0;
        end
        default: begin
          state <= charger_irq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // data pin: only ever pulled low, changed on falling clock edges
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOe_n <= 1'b1;
    end else if (startSeen || stopSeen) begin
      sdaOe_n <= 1'b1;
    end else if (sclFall) begin
      case (state)
        charger_irq_pkg::ST_ADDR: sdaOe_n <= !(byteDone && addrMatch);
        charger_irq_pkg::ST_REG, charger_irq_pkg::ST_WDATA: sdaOe_n <= !byteDone;
        charger_irq_pkg::ST_ADDR_ACK: sdaOe_n <= !(rwBit && !readData[7]);
        charger_irq_pkg::ST_RDATA: sdaOe_n <= byteDone || txShift[6];
        charger_irq_pkg::ST_RDATA_ACK: sdaOe_n <= !(masterAck && !readData[7]);
        default: sdaOe_n <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      txShift <= 8'h00;
    end else if (loadTx) begin
      txShift <= readData;
    end else if (sclFall && state == charger_irq_pkg::ST_RDATA && !byteDone) begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  // register pointer auto-increments after each byte written and as each read byte is loaded
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr <= charger_irq_pkg::POINTER_RESET;
    end else if (sclFall && state == charger_irq_pkg::ST_REG && byteDone) begin
      ptr <= shiftIn;
    end else if (wrStrobe || loadTx) begin
      ptr <= ptr + 8'h01;
    end
  end

  // start or stop after two or more bits of a byte, or a write to no mask
  // register; a legal stop or repeated start always follows one clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busErrorPulse <= 1'b0;
    end else begin
      busErrorPulse <= ((startSeen || stopSeen) && bitCnt > 4'h1 &&
        (inByte || state == charger_irq_pkg::ST_RDATA)) || (wrStrobe && !wrMapped);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      maskFaults <= charger_irq_pkg::MASK_FAULTS_RESET;
      maskEvents <= charger_irq_pkg::MASK_EVENTS_RESET;
      maskBusError <= charger_irq_pkg::MASK_BUS_ERROR_RESET;
    end else if (wrStrobe) begin
      if (ptr == charger_irq_pkg::MASK_FAULTS_ADDR) begin
        maskFaults <= shiftIn;
      end
      if (ptr == charger_irq_pkg::MASK_EVENTS_ADDR) begin
        maskEvents <= shiftIn;
      end
      if (ptr == charger_irq_pkg::IRQ_AND_OTG_STATUS_ADDR) begin
        maskBusError <= shiftIn[charger_irq_pkg::MASK_BUS_ERROR_BIT];
      end
    end
  end

  // status low bits are live mirrors; cause bytes clear as they are read
  always_comb begin
    readData = 8'h00;
    case (ptr)
      charger_irq_pkg::MASK_FAULTS_ADDR: readData = maskFaults;
      charger_irq_pkg::MASK_EVENTS_ADDR: readData = maskEvents;
      charger_irq_pkg::IRQ_AND_OTG_STATUS_ADDR: begin
        readData = {maskBusError, batCcS, outCcS, cutoffS, batOvS, otgStateS};
      end
      charger_irq_pkg::CAUSE_LOW_ADDR: readData = pendVec[7:0];
      charger_irq_pkg::CAUSE_MID_ADDR: readData = pendVec[15:8];
      charger_irq_pkg::CAUSE_HIGH_ADDR: readData = {7'h00, pendVec[16]};
      default: readData = 8'h00;
    endcase
  end

  always_comb begin
    clearVec = '0;
    if (loadTx) begin
      case (ptr)
        charger_irq_pkg::CAUSE_LOW_ADDR: clearVec[7:0] = 8'hff;
        charger_irq_pkg::CAUSE_MID_ADDR: clearVec[15:8] = 8'hff;
        charger_irq_pkg::CAUSE_HIGH_ADDR: clearVec[16] = 1'b1;
        default: clearVec = '0;
      endcase
    end
  end

  assign maskVec = {maskBusError, maskEvents, maskFaults};

  always_comb begin
    eventLevel = '0;
    eventLevel[charger_irq_pkg::EVT_CHARGE_DONE] = termS || fullS;
    eventLevel[charger_irq_pkg::EVT_BAT_GOOD_DROP] = !goodS;
    eventLevel[charger_irq_pkg::EVT_INPUT_WINDOW] = chgS && inFaultS;
    eventLevel[charger_irq_pkg::EVT_OTG_BATTERY] = otgS && (cutoffS || batOvS);
    eventLevel[charger_irq_pkg::EVT_SAFETY_TIMER] = chgS && (lowTmrS || fastTmrS);
    eventLevel[charger_irq_pkg::EVT_CHG_BAT_OV] = chgS && chgOvS;
    eventLevel[charger_irq_pkg::EVT_REGULATOR] = regFaultS;
    eventLevel[charger_irq_pkg::EVT_THERMAL] = thermS;
    eventLevel[charger_irq_pkg::EVT_SWITCH_OC] = switchOcS;
    eventLevel[charger_irq_pkg::EVT_WATCHDOG] = wdogS;
    eventLevel[charger_irq_pkg::EVT_HICCUP] = otgStateS == charger_irq_pkg::OTG_HICCUP_CODE;
    eventLevel[charger_irq_pkg::EVT_LIGHT_LOAD] =
      otgStateS == charger_irq_pkg::OTG_LIGHT_LOAD_CODE;
    eventLevel[charger_irq_pkg::EVT_DATA_READY] = dataRdyS;
    eventLevel[charger_irq_pkg::EVT_HIGH_IMP] = hizS;
    eventLevel[charger_irq_pkg::EVT_SUSPEND] = chgS && suspendS;
    eventLevel[charger_irq_pkg::EVT_OTG_TEMP] = otgS && (hotS || coldS);
    eventLevel[charger_irq_pkg::EVT_BUS_ERROR] = busErrorPulse;
  end

  irq_chan_if chanIf [NEV] ();

  for (genvar k = 0; k < NEV; k++) begin : g_chan
    assign chanIf[k].level = eventLevel[k];
    assign chanIf[k].mask = maskVec[k];
    assign chanIf[k].clear = clearVec[k];
    assign pendVec[k] = chanIf[k].pending;
    irq_event_chan u_chan (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .chan(chanIf[k])
    );
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hostAlertPin_n <= 1'b1;
    end else begin
      hostAlertPin_n <= !(|pendVec);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_charge_done: assert property (
    $rose(eventLevel[7]) && !maskVec[7] |-> ##2 !hostAlertPin_n)
    else $error("charge done did not reach the alert pin");
  a_battery_drop: assert property (
    $rose(eventLevel[6]) && !maskVec[6] |=> pendVec[6] ##1 !hostAlertPin_n)
    else $error("battery good drop not flagged");
  a_input_window: assert property (
    $rose(eventLevel[5]) && !maskVec[5] |-> ##2 !hostAlertPin_n)
    else $error("input window fault did not reach the pin");
  a_otg_battery: assert property (
    maskVec[4] && !pendVec[4] |=> !pendVec[4])
    else $error("masked reverse battery fault pending");
  a_safety_timer: assert property (
    $rose(eventLevel[3]) && !maskVec[3] |=> pendVec[3])
    else $error("safety timer expiry not flagged");
  a_chg_overvolt: assert property (
    $rose(eventLevel[2]) && !maskVec[2] |-> ##2 !hostAlertPin_n)
    else $error("battery overvoltage did not reach the pin");
  a_regulator: assert property (
    $rose(eventLevel[1]) && !maskVec[1] |=> pendVec[1] ##1 !hostAlertPin_n)
    else $error("regulator fault not flagged");
  a_thermal: assert property (
    maskVec[0] && !pendVec[0] |=> !pendVec[0])
    else $error("masked thermal event pending");
  a_switch_oc: assert property (
    $rose(eventLevel[15]) && !maskVec[15] |-> ##2 !hostAlertPin_n)
    else $error("switch overcurrent did not reach the pin");
  a_watchdog: assert property (
    $rose(eventLevel[14]) && !maskVec[14] |=> pendVec[14])
    else $error("watchdog expiry not flagged");
  a_hiccup: assert property (
    $rose(eventLevel[13]) && !maskVec[13] |-> ##2 !hostAlertPin_n)
    else $error("hiccup entry did not reach the pin");
  a_light_load: assert property (
    maskVec[12] && !pendVec[12] |=> !pendVec[12])
    else $error("masked light load event pending");
  a_data_ready: assert property (
    $rose(eventLevel[11]) && !maskVec[11] |=> pendVec[11] ##1 !hostAlertPin_n)
    else $error("data ready not flagged");
  a_high_imp: assert property (
    $rose(eventLevel[10]) && !maskVec[10] |-> ##2 !hostAlertPin_n)
    else $error("high impedance entry did not reach the pin");
  a_suspend: assert property (
    $rose(eventLevel[9]) && !maskVec[9] |=> pendVec[9])
    else $error("suspend entry not flagged");
  a_otg_temp: assert property (
    $rose(eventLevel[8]) && !maskVec[8] |-> ##2 !hostAlertPin_n)
    else $error("battery temperature event did not reach the pin");
  a_bus_error: assert property (
    busErrorPulse && !maskVec[16] |=> pendVec[16] ##1 !hostAlertPin_n)
    else $error("bus error not flagged");
  a_alert_release: assert property (
    pendVec == '0 |=> hostAlertPin_n)
    else $error("alert low with nothing pending");
  a_alert_hold: assert property (
    pendVec != '0 |=> !hostAlertPin_n)
    else $error("alert high while an event is pending");
endmodule : charger_irq_mask_logic

/* File: i2c_host_model.sv */
// host-side serial master that drives the bus clock and the open-drain data line
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic core_clk,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  output logic scl,
  output logic sda
);
  logic drv;
  // pull-up: a released line reads high, never the last value
  assign sda = drv & (sdaOe_n | sdaOut);
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask : w
  // a then b with clock high: (1,0) is a start, (0,1) a stop
  task automatic edge_seq(input logic a, input logic b);
    scl = 1'b0;
    w(3);
    drv = a;
    w(3);
    scl = 1'b1;
    w(6);
    drv = b;
    w(6);
  endtask : edge_seq
  task automatic clk_bit(input logic b, output logic s);
    scl = 1'b0;
    w(3);
    drv = b;
    w(3);
    scl = 1'b1;
    w(6);
    s = sda;
  endtask : clk_bit
  task automatic put(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ok = ok & ~s;
  endtask : put
  task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    ok = 1'b1;
    edge_seq(1'b1, 1'b0);
    put({dv, 1'b0}, ok);
    put(a, ok);
    put(d, ok);
    edge_seq(1'b0, 1'b1);
  endtask : wr
  task automatic rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    logic s;
    ok = 1'b1;
    edge_seq(1'b1, 1'b0);
    put({dv, 1'b0}, ok);
    put(a, ok);
    edge_seq(1'b1, 1'b0);
    put({dv, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(1'b1, s);
    edge_seq(1'b0, 1'b1);
  endtask : rd
endmodule : i2c_host_model

/* File: charger_irq_mask_logic_tb.sv */
// register and alert-pin tests of the charger interrupt mask block
`timescale 1ns/1ps
module charger_irq_mask_logic_tb;
  localparam logic [6:0] DEV = 7'h2a;
  logic core_clk, reset_n, sclIn, sdaIn, sdaOut, sdaOe_n, hostAlertPin_n, ok;
  logic chargeMode, reverseSupplyMode, chargeTerminatedState, chargeFullState;
  logic batteryGood, chargeInputFault, lowBatteryTimerExpired, fastChargeTimerExpired;
  logic chargeBatteryOvervolt, regulatorFault, thermalShutdown, switchOvercurrent;
  logic watchdogExpired, converterDataReady, highImpedanceState, chargeSuspend;
  logic otgBatteryHot, otgBatteryCold, otgBatteryCutoff, otgBatteryOvervolt;
  logic otgBatteryCc, otgOutputCc;
  logic [2:0] otgState;
  logic [7:0] d, ca, ma, ce;
  int miscompares, cmp_count;
  charger_irq_mask_logic #(.DEV_ADDR(DEV)) u_charger_irq_mask_logic (.core_clk(core_clk),
    .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .hostAlertPin_n(hostAlertPin_n), .chargeMode(chargeMode),
    .reverseSupplyMode(reverseSupplyMode), .chargeTerminatedState(chargeTerminatedState),
    .chargeFullState(chargeFullState), .batteryGood(batteryGood),
    .chargeInputFault(chargeInputFault), .lowBatteryTimerExpired(lowBatteryTimerExpired),
    .fastChargeTimerExpired(fastChargeTimerExpired),
    .chargeBatteryOvervolt(chargeBatteryOvervolt), .regulatorFault(regulatorFault),
    .thermalShutdown(thermalShutdown), .switchOvercurrent(switchOvercurrent),
    .watchdogExpired(watchdogExpired), .otgState(otgState),
    .converterDataReady(converterDataReady), .highImpedanceState(highImpedanceState),
    .chargeSuspend(chargeSuspend), .otgBatteryHot(otgBatteryHot),
    .otgBatteryCold(otgBatteryCold), .otgBatteryCutoff(otgBatteryCutoff),
    .otgBatteryOvervolt(otgBatteryOvervolt), .otgBatteryCc(otgBatteryCc),
    .otgOutputCc(otgOutputCc));
  i2c_host_model u_i2c_host_model (.core_clk(core_clk), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .scl(sclIn), .sda(sdaIn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_i2c_host_model.wr(DEV, a, v, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_i2c_host_model.rd(DEV, a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rd
  // s picks the second source of a two-source event
  task automatic ev(input int k, input logic s, input logic v);
    case (k)
      0: thermalShutdown = v;
      1: regulatorFault = v;
      2: chargeBatteryOvervolt = v;
      3: if (s) fastChargeTimerExpired = v; else lowBatteryTimerExpired = v;
      4: if (s) otgBatteryOvervolt = v; else otgBatteryCutoff = v;
      5: chargeInputFault = v;
      6: batteryGood = ~v;
      7: if (s) chargeFullState = v; else chargeTerminatedState = v;
      8: if (s) otgBatteryCold = v; else otgBatteryHot = v;
      9: chargeSuspend = v;
      10: highImpedanceState = v;
      11: converterDataReady = v;
      12: otgState = v ? 3'h4 : 3'h0;
      13: otgState = v ? 3'h3 : 3'h0;
      14: watchdogExpired = v;
      15: switchOvercurrent = v;
      default: if (v) wr(8'h30, 8'h00);
    endcase
  endtask : ev
  initial begin
    {reset_n, chargeTerminatedState, chargeFullState, chargeInputFault} = '0;
    {lowBatteryTimerExpired, fastChargeTimerExpired, chargeBatteryOvervolt} = '0;
    {regulatorFault, thermalShutdown, switchOvercurrent, watchdogExpired} = '0;
    {converterDataReady, highImpedanceState, chargeSuspend, otgBatteryHot} = '0;
    {otgBatteryCold, otgBatteryCutoff, otgBatteryOvervolt, otgBatteryCc} = '0;
    {otgOutputCc, otgState} = '0;
    {batteryGood, chargeMode, reverseSupplyMode} = 3'h7;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({7'h00, hostAlertPin_n}, 8'h01);
    chk({6'h00, sdaOut, sdaOe_n}, 8'h01);
    rd(8'h1e, charger_irq_pkg::MASK_FAULTS_RESET);
    rd(8'h1f, charger_irq_pkg::MASK_EVENTS_RESET);
    wr(8'h1e, 8'ha5);
    wr(8'h1f, 8'h5a);
    rd(8'h1e, 8'ha5);
    rd(8'h1f, 8'h5a);
    wr(8'h1e, 8'h00);
    wr(8'h1f, 8'h00);
    // only the top bit of the status byte is writable
    otgBatteryCc = 1'b1;
    otgState = 3'h2;
    wr(8'h20, 8'hff);
    rd(8'h20, 8'hc2);
    wr(8'h20, 8'h00);
    otgBatteryCc = 1'b0;
    otgState = 3'h0;
    rd(8'h31, 8'h00);
    u_i2c_host_model.wr(DEV ^ 7'h01, 8'h1e, 8'hff, ok);
    chk({7'h00, ok}, 8'h00);
    rd(8'h1e, 8'h00);
    for (int k = 0; k < 17; k++) begin
      ce = 8'h01 << (k % 8);
      ca = (k < 8) ? 8'h3c : (k < 16) ? 8'h3d : 8'h3e;
      ma = (k < 8) ? 8'h1e : (k < 16) ? 8'h1f : 8'h20;
      ev(k, 1'b0, 1'b1);
      for (int i = 0; i < 20 && hostAlertPin_n !== 1'b0; i++) @(negedge core_clk);
      chk({7'h00, hostAlertPin_n}, 8'h00);
      if (hostAlertPin_n !== 1'b0) stop_test;
      rd(ca, ce);
      rd(ca, 8'h00);
      chk({7'h00, hostAlertPin_n}, 8'h01);
      ev(k, 1'b0, 1'b0);
      wr(ma, (k == 16) ? 8'h80 : ce);
      ev(k, 1'b1, 1'b1);
      repeat (20) @(negedge core_clk);
      chk({7'h00, hostAlertPin_n}, 8'h01);
      ev(k, 1'b1, 1'b0);
      rd(ca, 8'h00);
      wr(ma, 8'h00);
    end
    // events outside their mode must not reach the pin
    {chargeMode, reverseSupplyMode} = 2'b00;
    ev(5, 1'b0, 1'b1);
    ev(8, 1'b0, 1'b1);
    repeat (20) @(negedge core_clk);
    chk({7'h00, hostAlertPin_n}, 8'h01);
    ev(5, 1'b0, 1'b0);
    ev(8, 1'b0, 1'b0);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    stop_test;
  end
endmodule : charger_irq_mask_logic_tb
